// ### verilog/cgw_pkg.sv
// Purpose: Shared constants for the clock generator control and watchdog bytes
// Assumes: 100 MHz reference clock, byte wide register access
// Notes:   Offsets are byte addresses of the register port
package cgw_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] CGW_PERIPHERAL_CLOCK_CONTROL = 8'h04;
  localparam logic [7:0] CGW_MEMORY_CLOCK_CONTROL = 8'h05;
  localparam logic [7:0] CGW_WATCHDOG_CONTROL = 8'h06;
  localparam logic [7:0] CGW_PLL_N_DIVIDER = 8'h07;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] CGW_PERIPH_RST = 8'hcf;
  localparam logic [7:0] CGW_MEMORY_RST = 8'h7f;
  localparam logic [7:0] CGW_WATCHDOG_RST = 8'h80;
  localparam logic [7:0] CGW_PLL_N_RST = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  // Peripheral clock control
  localparam int CGW_USB_DRV_BIT = 7;
  localparam int CGW_SEL_IO_DRV_BIT = 6;
  localparam int CGW_RATIO_MSB = 5;
  localparam int CGW_RATIO_LSB = 4;
  localparam int CGW_REF_A_EN_BIT = 3;
  localparam int CGW_REF_B_EN_BIT = 2;
  localparam int CGW_REF_A_DRV_BIT = 1;
  localparam int CGW_REF_B_DRV_BIT = 0;
  // Memory clock control
  localparam int CGW_THRESH_BIT = 7;
  localparam int CGW_FEEDBACK_EN_BIT = 6;
  localparam int CGW_MEM_EN_MSB = 5;
  localparam int CGW_MEM_EN_LSB = 0;
  // Watchdog control
  localparam int CGW_PIN_FN_BIT = 7;
  localparam int CGW_REVERT_BIT = 6;
  localparam int CGW_WD_TEST_BIT = 5;
  localparam int CGW_WATCHDOG_ALARM_FLAG_BIT = 4;
  localparam int CGW_WD_SEL_MSB = 3;
  localparam int CGW_WD_SEL_LSB = 0;
  // Divider byte
  localparam int CGW_N_RSVD_BIT = 7;
  localparam int CGW_N_MSB = 6;

  // ----------------------------------------------------------------------
  // Watchdog and ratio codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] CGW_WD_OFF = 4'h0;
  localparam logic [3:0] CGW_WD_LAST_SEC = 4'h1;
  localparam logic [1:0] CGW_RATIO_DEFAULT = 2'h0;
  localparam logic [1:0] CGW_RATIO_2_1 = 2'h1;
  localparam logic [1:0] CGW_RATIO_2P5_1 = 2'h2;
  localparam logic [1:0] CGW_RATIO_3_1 = 2'h3;

  // ----------------------------------------------------------------------
  // Buffer input thresholds in millivolts
  // ----------------------------------------------------------------------
  localparam logic [10:0] CGW_DDR_THR0_MV = 11'd1150;
  localparam logic [10:0] CGW_DDR_THR1_MV = 11'd1050;
  localparam logic [10:0] CGW_SDR_THR0_MV = 11'd1350;
  localparam logic [10:0] CGW_SDR_THR1_MV = 11'd1250;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CGW_CLK_PERIOD_NS = 10;
  localparam int unsigned CGW_SECOND_NS = 1000000000;
  localparam int unsigned CGW_SECOND_CYCLES = CGW_SECOND_NS / CGW_CLK_PERIOD_NS;
  localparam int unsigned CGW_RST_PULSE_NS = 1000;
  localparam int unsigned CGW_RST_PULSE_CYCLES =
    (CGW_RST_PULSE_NS + CGW_CLK_PERIOD_NS - 1) / CGW_CLK_PERIOD_NS;

endpackage

// ### verilog/cgw_sec_tick.sv
// Purpose: One-second timebase for the watchdog
// Assumes: Runs on the reference clock, restart aligns the next tick
// Notes:   tick_o is a one-cycle pulse every TICK_CYCLES enabled cycles
`timescale 1ns/100ps
module cgw_sec_tick
  import cgw_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = CGW_SECOND_CYCLES
)
(
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Control
  input wire logic restart_i,
  // Tick
  output logic tick_o
);

  logic [31:0] cnt;

  // ----------------------------------------------------------------------
  // Prescaler, restart so a timeout is a whole number of seconds
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt <= 32'h0;
      tick_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (restart_i || cnt == TICK_CYCLES - 1)
        cnt <= 32'h0;
      else
        cnt <= cnt + 32'h1;
      tick_o <= !restart_i && (cnt == TICK_CYCLES - 1);
    end
  end

endmodule // cgw_sec_tick

// ### verilog/cgw_regs.sv
// Purpose: Control bytes 4 to 7 of a clock generator, with watchdog
// Assumes: Register port driven by the serial management engine on ref_clk_i
// Notes:   Clock gating itself sits in the output buffers fed by the enables
//
// Summary of operation
// - Drive bits of the USB, selectable and reference clocks: one is normal, zero is high.
// - Each output enable keeps its clock running when one and stops it low when zero.
// - The second reference output's enable and drive bits act only in alternate CPU mode.
// - The ratio field keeps the default at 00 and picks 2/1, 2.5/1, 3/1 for 01, 10, 11.
// - The threshold bit picks 1.15V/1.05V in DDR mode and 1.35V/1.25V in SDR mode.
// - Pin function bit: one makes the shared pin a power-down input, zero a reset output.
// - After a watchdog reboot the revert bit picks strapped (0) or second-to-last (1) setting.
// - The alarm flag sets on a timeout and clears when the host clears the timeout field.
// - A zero timeout field turns the watchdog off, any n from 1 to 15 gives n seconds.
// - Bits 6 to 0 of the divider byte hold the PLL N value, bit 6 most significant.
// - Bit 7 of the divider byte powers up zero and the host leaves it zero.
// - Each timeout pulses reset low, sets the alarm and restarts; later ones also revert.
// - N and R go to the PLL only on a rising edge of the dial latch enable.
`timescale 1ns/100ps
module cgw_regs
  import cgw_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = CGW_SECOND_CYCLES,
  parameter int unsigned MEM_CLKS = 6
)
(
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Straps, from pins
  input wire logic alt_cpu_mode_i,
  input wire logic ddr_mode_i,
  // Shared pin
  input wire logic shared_pin_i,
  output logic shared_pin_o,
  output logic shared_pin_oe_o,
  output logic power_down_in_n_o,
  // Dial latch, from the R control byte
  input wire logic dial_latch_enable_i,
  input wire logic [5:0] pll_r_value_i,
  output logic [6:0] pll_n_latched_o,
  output logic [5:0] pll_r_latched_o,
  // Clock output controls
  output logic usb_clock_out_drive_normal_o,
  output logic selectable_usb_io_clock_drive_normal_o,
  output logic reference_out_a_en_o,
  output logic reference_out_a_drive_normal_o,
  output logic reference_out_b_en_o,
  output logic reference_out_b_drive_normal_o,
  output logic feedback_out_en_o,
  output logic [MEM_CLKS-1:0] mem_clk_en_o,
  output logic [1:0] clock_ratio_select_o,
  output logic [10:0] buf_threshold_mv_o,
  // Watchdog recovery
  output logic freq_revert_pulse_o,
  output logic freq_revert_second_last_o
);

  logic [7:0] periph;
  logic [7:0] memory;
  logic [7:0] pll_n;
  logic pin_fn;
  logic revert_sel;
  logic wd_test_bit;
  logic watchdog_alarm_flag;
  logic [3:0] watchdog_timeout_sel;
  logic [3:0] wd_left;
  logic wd_once;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic dial_q;
  logic dial_rise;
  logic tick;
  logic wd_write;
  logic sel_nz_write;
  logic field_clear;
  logic timeout;
  logic [7:0] rst_cnt;
  logic sys_rst_n;

  // ----------------------------------------------------------------------
  // Pin synchronisers: first stage feeds only the second
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      // Pin stage resets to its idle high, else a false power-down follows reset
      sync1 <= 3'h4;
      sync2 <= 3'h4;
    end
    else if (ce_i)
    begin
      sync1 <= {shared_pin_i, ddr_mode_i, alt_cpu_mode_i};
      sync2 <= sync1;
    end
  end

  // Decoded strobes
  assign wd_write = ce_i && reg_wr_i && reg_addr_i == CGW_WATCHDOG_CONTROL;
  assign sel_nz_write = wd_write && reg_wdata_i[CGW_WD_SEL_MSB:CGW_WD_SEL_LSB] != CGW_WD_OFF;
  assign field_clear = wd_write && reg_wdata_i[CGW_WD_SEL_MSB:CGW_WD_SEL_LSB] == CGW_WD_OFF;
  assign timeout = ce_i && tick && watchdog_timeout_sel != CGW_WD_OFF
                   && wd_left == CGW_WD_LAST_SEC;
  assign dial_rise = ce_i && dial_latch_enable_i && !dial_q;

  // ----------------------------------------------------------------------
  // Plain control bytes
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      periph <= CGW_PERIPH_RST;
      memory <= CGW_MEMORY_RST;
      pll_n <= CGW_PLL_N_RST;
    end
    else if (ce_i && reg_wr_i)
    begin
      case (reg_addr_i)
        CGW_PERIPHERAL_CLOCK_CONTROL: periph <= reg_wdata_i;
        CGW_MEMORY_CLOCK_CONTROL: memory <= reg_wdata_i;
        CGW_PLL_N_DIVIDER: pll_n <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Watchdog byte: alarm is read-only, set beats clear
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pin_fn <= CGW_WATCHDOG_RST[CGW_PIN_FN_BIT];
      revert_sel <= CGW_WATCHDOG_RST[CGW_REVERT_BIT];
      wd_test_bit <= CGW_WATCHDOG_RST[CGW_WD_TEST_BIT];
      watchdog_alarm_flag <= CGW_WATCHDOG_RST[CGW_WATCHDOG_ALARM_FLAG_BIT];
      watchdog_timeout_sel <= CGW_WATCHDOG_RST[CGW_WD_SEL_MSB:CGW_WD_SEL_LSB];
    end
    else
    begin
      if (wd_write)
      begin
        pin_fn <= reg_wdata_i[CGW_PIN_FN_BIT];
        revert_sel <= reg_wdata_i[CGW_REVERT_BIT];
        wd_test_bit <= reg_wdata_i[CGW_WD_TEST_BIT]; // Host keeps it zero
        watchdog_timeout_sel <= reg_wdata_i[CGW_WD_SEL_MSB:CGW_WD_SEL_LSB];
      end
      if (timeout)
        watchdog_alarm_flag <= 1'b1;
      else if (field_clear)
        watchdog_alarm_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Watchdog second counter and timeout history
  // ----------------------------------------------------------------------
  cgw_sec_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .restart_i(sel_nz_write || timeout),
    .tick_o(tick)
  );

  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wd_left <= CGW_WD_OFF;
      wd_once <= 1'b0;
    end
    else if (ce_i)
    begin
      if (sel_nz_write)
        wd_left <= reg_wdata_i[CGW_WD_SEL_MSB:CGW_WD_SEL_LSB];
      else if (timeout)
        wd_left <= watchdog_timeout_sel;
      else if (tick && wd_left != CGW_WD_OFF)
        wd_left <= wd_left - 4'h1;
      // Timeout wins over a clear in the same cycle
      if (timeout)
        wd_once <= 1'b1;
      else if (field_clear)
        wd_once <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // System reset pulse, stretched so the board sees a clean low
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_cnt <= 8'h0;
      sys_rst_n <= 1'b1;
    end
    else if (ce_i)
    begin
      if (timeout)
        rst_cnt <= 8'(CGW_RST_PULSE_CYCLES - 1);
      else if (rst_cnt != 8'h0)
        rst_cnt <= rst_cnt - 8'h1;
      sys_rst_n <= !(timeout || rst_cnt != 8'h0);
    end
  end

  // ----------------------------------------------------------------------
  // Dial latch: divider values move only on the enable's rising edge
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      dial_q <= 1'b0;
      pll_n_latched_o <= 7'h0;
      pll_r_latched_o <= 6'h0;
    end
    else if (ce_i)
    begin
      dial_q <= dial_latch_enable_i;
      if (dial_rise)
      begin
        pll_n_latched_o <= pll_n[CGW_N_MSB:0];
        pll_r_latched_o <= pll_r_value_i;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs, all from flops
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      usb_clock_out_drive_normal_o <= CGW_PERIPH_RST[CGW_USB_DRV_BIT];
      selectable_usb_io_clock_drive_normal_o <= CGW_PERIPH_RST[CGW_SEL_IO_DRV_BIT];
      reference_out_a_en_o <= CGW_PERIPH_RST[CGW_REF_A_EN_BIT];
      reference_out_a_drive_normal_o <= CGW_PERIPH_RST[CGW_REF_A_DRV_BIT];
      reference_out_b_en_o <= 1'b0;
      reference_out_b_drive_normal_o <= 1'b1;
      feedback_out_en_o <= CGW_MEMORY_RST[CGW_FEEDBACK_EN_BIT];
      mem_clk_en_o <= '1;
      clock_ratio_select_o <= CGW_RATIO_DEFAULT;
      buf_threshold_mv_o <= CGW_SDR_THR0_MV;
      shared_pin_o <= 1'b1;
      shared_pin_oe_o <= 1'b0;
      power_down_in_n_o <= 1'b1;
      freq_revert_pulse_o <= 1'b0;
      freq_revert_second_last_o <= 1'b0;
    end
    else if (ce_i)
    begin
      usb_clock_out_drive_normal_o <= periph[CGW_USB_DRV_BIT];
      selectable_usb_io_clock_drive_normal_o <= periph[CGW_SEL_IO_DRV_BIT];
      reference_out_a_en_o <= periph[CGW_REF_A_EN_BIT];
      reference_out_a_drive_normal_o <= periph[CGW_REF_A_DRV_BIT];
      // Outside alternate mode the pin is not a reference: held off, normal drive
      reference_out_b_en_o <= sync2[0] && periph[CGW_REF_B_EN_BIT];
      reference_out_b_drive_normal_o <= !sync2[0] || periph[CGW_REF_B_DRV_BIT];
      feedback_out_en_o <= memory[CGW_FEEDBACK_EN_BIT];
      mem_clk_en_o <= memory[CGW_MEM_EN_LSB +: MEM_CLKS];
      clock_ratio_select_o <= periph[CGW_RATIO_MSB:CGW_RATIO_LSB];
      if (sync2[1])
        buf_threshold_mv_o <= memory[CGW_THRESH_BIT] ? CGW_DDR_THR1_MV : CGW_DDR_THR0_MV;
      else
        buf_threshold_mv_o <= memory[CGW_THRESH_BIT] ? CGW_SDR_THR1_MV : CGW_SDR_THR0_MV;
      shared_pin_o <= sys_rst_n;
      shared_pin_oe_o <= !pin_fn;
      power_down_in_n_o <= !pin_fn || sync2[2];
      freq_revert_pulse_o <= timeout && wd_once;
      freq_revert_second_last_o <= revert_sel;
    end
  end

  // ----------------------------------------------------------------------
  // Read data, one cycle after the strobe; unmapped reads zero
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      reg_rdata_o <= 8'h0;
    else if (ce_i && reg_rd_i)
    begin
      case (reg_addr_i)
        CGW_PERIPHERAL_CLOCK_CONTROL: reg_rdata_o <= periph;
        CGW_MEMORY_CLOCK_CONTROL: reg_rdata_o <= memory;
        CGW_WATCHDOG_CONTROL: reg_rdata_o <= {pin_fn, revert_sel, wd_test_bit,
                                              watchdog_alarm_flag, watchdog_timeout_sel};
        CGW_PLL_N_DIVIDER: reg_rdata_o <= pll_n;
        default: reg_rdata_o <= 8'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_alarm_set;
    timeout |=> watchdog_alarm_flag;
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm not set on timeout");

  property p_alarm_clr;
    field_clear && !timeout |=> !watchdog_alarm_flag;
  endproperty
  a_alarm_clr: assert property (p_alarm_clr) else $error("alarm not cleared");

  property p_wd_off;
    watchdog_timeout_sel == CGW_WD_OFF |-> !timeout;
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("timeout while watchdog off");

  property p_reload;
    sel_nz_write |=> wd_left == $past(reg_wdata_i[3:0]);
  endproperty
  a_reload: assert property (p_reload) else $error("counter not reloaded");

  property p_rst_pulse;
    timeout && ce_i |=> (!sys_rst_n && ce_i) [*1] ##0 (!sys_rst_n || !ce_i) [*8];
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too short");

  property p_revert;
    timeout |=> freq_revert_pulse_o == $past(wd_once);
  endproperty
  a_revert: assert property (p_revert) else $error("revert pulse wrong");

  property p_pin_fn;
    ce_i ##1 ce_i |-> shared_pin_oe_o == !$past(pin_fn);
  endproperty
  a_pin_fn: assert property (p_pin_fn) else $error("pin direction wrong");

  property p_ref_b;
    ce_i && !sync2[0] |=> !reference_out_b_en_o && reference_out_b_drive_normal_o;
  endproperty
  a_ref_b: assert property (p_ref_b) else $error("second reference active off mode");

  property p_nlatch;
    dial_rise |=> pll_n_latched_o == $past(pll_n[6:0]);
  endproperty
  a_nlatch: assert property (p_nlatch) else $error("N not latched");

  property p_nhold;
    !dial_rise |=> $stable(pll_n_latched_o) && $stable(pll_r_latched_o);
  endproperty
  a_nhold: assert property (p_nhold) else $error("divider moved without edge");

  c_timeout: cover property (timeout);
  c_second_timeout: cover property (timeout && wd_once);
  c_dial: cover property (dial_rise);
  c_reset_out: cover property (!pin_fn && !sys_rst_n);

endmodule // cgw_regs

// ### testbench/cgw_r_byte_model.sv
// Purpose: Far side model: R control byte and shared pin neighbour
// Assumes: Tasks are entered at a falling edge of ref_clk_i
// Notes:   The pin shows the power-down source whenever the device lets go
`timescale 1ns/100ps
module cgw_r_byte_model
(
  // Clock
  input wire logic ref_clk_i,
  // Shared pin, device side
  input wire logic shared_pin_o,
  input wire logic shared_pin_oe_o,
  output logic pin_level_o,
  // R byte
  output logic dial_latch_enable_o,
  output logic [5:0] pll_r_value_o
);
  logic pd_n;

  // Wire level: device drives while enabled, otherwise the power-down source
  assign pin_level_o = shared_pin_oe_o ? shared_pin_o : pd_n;

  // Idle at time zero
  initial
  begin
    pd_n = 1'b1;
    dial_latch_enable_o = 1'b0;
    pll_r_value_o = 6'h00;
  end

  // Power-down source level
  task automatic set_pd(input logic v);
    pd_n = v;
  endtask

  // New R value with a latch rise; R held until the next rise
  task automatic rise(input logic [5:0] r);
    pll_r_value_o = r;
    dial_latch_enable_o = 1'b1;
    @(negedge ref_clk_i);
  endtask

  // A zero is needed between rises, else nothing latches
  task automatic fall();
    dial_latch_enable_o = 1'b0;
    @(negedge ref_clk_i);
  endtask
endmodule // cgw_r_byte_model

// ### testbench/tb_top.sv
// Purpose: Self-checking bench for the clock control and watchdog bytes
// Assumes: One second shortened to 20 cycles through TICK_CYCLES
// Notes:   Inputs change and outputs are sampled on the falling edge
`timescale 1ns/100ps
module tb_top;
  import cgw_pkg::*;
  localparam int T = 20;
  logic ref_clk_i, nrst_i, ce_i, reg_wr_i, reg_rd_i, alt_i, ddr_i, pin;
  logic pin_o, pin_oe, pd_o, den, rev_p, rev_sl, usb, sio, ra_en, ra_dr, rb_en, rb_dr, fb;
  logic [7:0] addr, wdata, rdata, po;
  logic [5:0] rv, rl, mem;
  logic [6:0] nl;
  logic [1:0] ratio;
  logic [10:0] thr, e;
  logic [7:0] pt [5] = '{8'h00, 8'hcf, 8'h35, 8'h5a, 8'ha6};
  logic [7:0] mt [4] = '{8'h00, 8'h7f, 8'h81, 8'hc0};
  logic [7:0] rt [4] = '{CGW_PERIPH_RST, CGW_MEMORY_RST, CGW_WATCHDOG_RST, CGW_PLL_N_RST};
  int miscompares, cmp_count, n, w, rev_cnt;

  assign po = {usb, sio, ratio, ra_en, rb_en, ra_dr, rb_dr};

  cgw_regs #(.TICK_CYCLES(T), .MEM_CLKS(6)) i_cgw_regs (.ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i), .ce_i(ce_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .alt_cpu_mode_i(alt_i),
    .ddr_mode_i(ddr_i), .shared_pin_i(pin), .shared_pin_o(pin_o), .shared_pin_oe_o(pin_oe),
    .power_down_in_n_o(pd_o), .dial_latch_enable_i(den), .pll_r_value_i(rv),
    .pll_n_latched_o(nl), .pll_r_latched_o(rl), .usb_clock_out_drive_normal_o(usb),
    .selectable_usb_io_clock_drive_normal_o(sio), .reference_out_a_en_o(ra_en),
    .reference_out_a_drive_normal_o(ra_dr), .reference_out_b_en_o(rb_en),
    .reference_out_b_drive_normal_o(rb_dr), .feedback_out_en_o(fb), .mem_clk_en_o(mem),
    .clock_ratio_select_o(ratio), .buf_threshold_mv_o(thr), .freq_revert_pulse_o(rev_p),
    .freq_revert_second_last_o(rev_sl));

  cgw_r_byte_model i_cgw_r_byte_model (.ref_clk_i(ref_clk_i), .shared_pin_o(pin_o),
    .shared_pin_oe_o(pin_oe), .pin_level_o(pin), .dial_latch_enable_o(den),
    .pll_r_value_o(rv));

  // 100 MHz clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // Catch the one-cycle revert pulse, too short to poll
  always @(posedge ref_clk_i)
    if (rev_p === 1'b1)
      rev_cnt <= rev_cnt + 1;

  // ----------------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    if (miscompares == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk_i);
  endtask

  // Write returns once the derived outputs have settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_i = 1'b1;
    addr = a;
    wdata = d;
    cyc(1);
    reg_wr_i = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_rd_i = 1'b1;
    addr = a;
    cyc(1);
    reg_rd_i = 1'b0;
    chk(rdata, exp);
    cyc(1);
  endtask

  // Bounded wait for the reset output to go low
  task automatic wait_low(output int k);
    k = 0;
    while (pin_o !== 1'b0)
    begin
      cyc(1);
      k++;
      if (k > 1000)
      begin
        miscompares++;
        report_and_stop();
      end
    end
  endtask

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial
  begin
    miscompares = 0;
    cmp_count = 0;
    nrst_i = 1'b0;
    ce_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    alt_i = 1'b0;
    ddr_i = 1'b0;
    cyc(4);
    nrst_i = 1'b1;
    cyc(1);
    chk(pd_o, 1'b1);
    for (int i = 0; i < 4; i++)
      rd(8'h04 + 8'(i), rt[i]);
    // Frozen clock enable drops the write; unmapped place reads zero
    ce_i = 1'b0;
    wr(CGW_MEMORY_CLOCK_CONTROL, 8'h00);
    ce_i = 1'b1;
    rd(CGW_MEMORY_CLOCK_CONTROL, 8'h7f);
    wr(8'h08, 8'hff);
    rd(8'h08, 8'h00);
    // Peripheral byte, both CPU modes
    for (int a = 0; a < 2; a++)
    begin
      alt_i = a[0];
      cyc(4);
      foreach (pt[i])
      begin
        wr(CGW_PERIPHERAL_CLOCK_CONTROL, pt[i]);
        chk(po, (a == 1) ? pt[i] : ((pt[i] & 8'hfa) | 8'h01));
        rd(CGW_PERIPHERAL_CLOCK_CONTROL, pt[i]);
      end
    end
    // Memory byte, both memory modes
    for (int m = 0; m < 2; m++)
    begin
      ddr_i = m[0];
      cyc(4);
      foreach (mt[i])
      begin
        wr(CGW_MEMORY_CLOCK_CONTROL, mt[i]);
        chk({fb, mem}, mt[i][6:0]);
        e = mt[i][7] ? CGW_SDR_THR1_MV : CGW_SDR_THR0_MV;
        if (m == 1)
          e = mt[i][7] ? CGW_DDR_THR1_MV : CGW_DDR_THR0_MV;
        chk(thr, e);
      end
    end
    // Shared pin as power-down input, then as reset output
    i_cgw_r_byte_model.set_pd(1'b0);
    cyc(4);
    chk({pin_oe, pd_o}, 2'b00);
    i_cgw_r_byte_model.set_pd(1'b1);
    wr(CGW_WATCHDOG_CONTROL, 8'h00);
    chk({pin_oe, pin_o, pd_o}, 3'b111);
    wr(CGW_WATCHDOG_CONTROL, 8'h40);
    chk(rev_sl, 1'b1);
    wr(CGW_WATCHDOG_CONTROL, 8'h10);
    rd(CGW_WATCHDOG_CONTROL, 8'h00);
    // One second timeout, then switched off
    wr(CGW_WATCHDOG_CONTROL, 8'h01);
    wait_low(n);
    chk(n >= T && n <= T + 4, 1'b1);
    wr(CGW_WATCHDOG_CONTROL, 8'h00);
    cyc(150);
    chk(pin_o, 1'b1);
    rd(CGW_WATCHDOG_CONTROL, 8'h00);
    // Eight seconds with revert to the earlier setting, two timeouts
    wr(CGW_WATCHDOG_CONTROL, 8'h48);
    wait_low(n);
    chk(n >= 8 * T && n <= 8 * T + 4, 1'b1);
    chk(16'(rev_cnt), 16'h0);
    rd(CGW_WATCHDOG_CONTROL, 8'h58);
    w = 2;
    while (pin_o === 1'b0 && w < 300)
    begin
      cyc(1);
      w++;
    end
    chk(w >= CGW_RST_PULSE_CYCLES && w <= CGW_RST_PULSE_CYCLES + 1, 1'b1);
    wait_low(n);
    chk(n + w >= 8 * T - 3 && n + w <= 8 * T + 3, 1'b1);
    chk(16'(rev_cnt), 16'h1);
    wr(CGW_WATCHDOG_CONTROL, 8'h40);
    rd(CGW_WATCHDOG_CONTROL, 8'h40);
    cyc(200);
    chk(pin_o, 1'b1);
    // Divider latched only on a rise of the latch enable
    wr(CGW_PLL_N_DIVIDER, 8'h55);
    rd(CGW_PLL_N_DIVIDER, 8'h55);
    i_cgw_r_byte_model.rise(6'h2a);
    cyc(1);
    chk({nl, rl}, {7'h55, 6'h2a});
    wr(CGW_PLL_N_DIVIDER, 8'h3c);
    chk({nl, rl}, {7'h55, 6'h2a});
    i_cgw_r_byte_model.fall();
    i_cgw_r_byte_model.rise(6'h11);
    cyc(1);
    chk({nl, rl}, {7'h3c, 6'h11});
    report_and_stop();
  end
endmodule // tb_top
